// File: hw/dpsem_phase_timer.sv
// Phase timer that counts one access phase and pulses when it ends
`timescale 1ns/1ps
`default_nettype none
`include "dpsem_defines.svh"

module dpsem_phase_timer (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  input  wire logic [3:0] len_i,
  output logic      done_o
);
  dpsem_pkg::dpsem_phase_type st_ff;
  dpsem_pkg::dpsem_phase_type nxt_st;
  logic                       done_ff;
  logic                       nxt_done;

  // ------------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    nxt_done = 1'b0;
    if (start_i) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = len_i;
    end else if (st_ff.busy) begin
      if (st_ff.cnt <= 4'h1) begin
        nxt_st.busy = 1'b0;
        nxt_done    = 1'b1; // One-cycle end pulse
      end else begin
        nxt_st.cnt = st_ff.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_ff   <= '0;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;
endmodule
`default_nettype wire

// File: hw/dpsem_port_ctrl.sv
// One-port controller that drives the semaphore space of a dual-port RAM
//
// Operation
// [RL1] The device holds eight semaphore latches apart from the memory array.
// [RL2] Flags are active low: write zero to request, write one from the same port to release.
// [RL3] The controller pulls the flag space select low and uses address, output enable, write.
// [RL4] The flag is chosen by the three low address bits; higher bits are ignored.
// [RL5] Only data bit zero carries the written value.
// [RL6] A zero into a free flag reads zero on the writer's port and one on the other.
// [RL7] The owner's one frees the flag for both ports unless the other port is pending.
// [RL8] A read returns the flag on every data bit.
// [RL9] The read value is captured when select and output enable go active and held.
// [RL10] Between successive polls the controller drops select or output enable.
// [RL11] Acquire writes zero first, then reads back; never read then write.
// [RL12] A request to a flag owned by the other port reads back one until handed over.
// [RL13] After a failed request the controller keeps re-reading or writes one to withdraw.
// [RL14] A release while the other port is pending hands ownership straight over.
// [RL15] Simultaneous requests grant exactly one port.
// [RL16] At power-up both ports write one to all eight flags to free them.
`timescale 1ns/1ps
`default_nettype none
`include "dpsem_defines.svh"

module dpsem_port_ctrl (
  input  wire logic                       mclk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       cmd_valid_i,
  input  wire logic [1:0]                 cmd_i,
  input  wire logic [`DPSEM_INDEX_W-1:0]  cmd_index_i,
  input  wire logic [7:0]                 poll_limit_i,
  output logic                            cmd_ready_o,
  output logic                            done_o,
  output logic                            granted_o,
  output logic                            flag_space_select_n_o,
  output logic                            oe_n_o,
  output logic                            rw_n_o,
  output logic [`DPSEM_ADDR_W-1:0]        addr_o,
  output logic [`DPSEM_DATA_W-1:0]        data_o,
  output logic                            data_oe_o,
  input  wire logic [`DPSEM_DATA_W-1:0]   data_i
);
  localparam logic [3:0] PHASE_LEN = 4'(`DPSEM_PHASE_CYC);
  localparam logic [3:0] GAP_LEN   = 4'(`DPSEM_GAP_CYC);

  typedef struct packed {
    dpsem_pkg::dpsem_state_type state;
    dpsem_pkg::dpsem_cmd_type   cmd;
    logic [`DPSEM_INDEX_W-1:0]  flag_index;
    logic [7:0]                 polls;
    logic                       ready;
    logic                       done;
    logic                       granted;
    logic                       sel_n;
    logic                       oe_n;
    logic                       rw_n;
    logic                       wbit;
    logic                       data_oe;
    logic                       gap_next_read;
  } dpsem_ctl_type;

  dpsem_ctl_type s_ff;
  dpsem_ctl_type nxt_s;
  logic          tmr_start;
  logic [3:0]    tmr_len;
  logic          tmr_done;

  // Flag read: any bit works since the device replicates it, use bit zero
  function automatic logic flag_low(input logic [`DPSEM_DATA_W-1:0] d);
    flag_low = ~d[`DPSEM_FLAG_BIT]; // see [RL8]
  endfunction

  dpsem_phase_timer u_timer (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .start_i (tmr_start),
    .len_i   (tmr_len),
    .done_o  (tmr_done)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    nxt_s     = s_ff;
    tmr_start = 1'b0;
    tmr_len   = PHASE_LEN;
    nxt_s.done = 1'b0;
    case (s_ff.state)
      dpsem_pkg::DPSEM_ST_IDLE: begin
        nxt_s.ready = 1'b1;
        if (cmd_valid_i && s_ff.ready) begin
          nxt_s.ready      = 1'b0;
          nxt_s.cmd        = dpsem_pkg::dpsem_cmd_type'(cmd_i);
          nxt_s.flag_index = (cmd_i == dpsem_pkg::DPSEM_CMD_INIT) ? '0 : cmd_index_i;
          nxt_s.polls      = 8'h00;
          nxt_s.granted    = 1'b0;
          // Acquire writes zero, release and init write one
          nxt_s.wbit       = (cmd_i != dpsem_pkg::DPSEM_CMD_ACQUIRE); // see [RL2]
          if (cmd_i != dpsem_pkg::DPSEM_CMD_NONE) begin
            nxt_s.state   = dpsem_pkg::DPSEM_ST_WRITE;
            nxt_s.sel_n   = 1'b0; // see [RL3]
            nxt_s.rw_n    = 1'b0;
            nxt_s.data_oe = 1'b1;
            tmr_start     = 1'b1;
          end
        end
      end
      dpsem_pkg::DPSEM_ST_WRITE: begin
        if (tmr_done) begin
          nxt_s.sel_n   = 1'b1;
          nxt_s.rw_n    = 1'b1;
          nxt_s.data_oe = 1'b0;
          tmr_start     = 1'b1;
          tmr_len       = GAP_LEN;
          nxt_s.state   = dpsem_pkg::DPSEM_ST_GAP;
          // Write before read on acquire; release and init need no read
          nxt_s.gap_next_read = (s_ff.cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE); // see [RL11]
        end
      end
      dpsem_pkg::DPSEM_ST_GAP: begin
        // Select and output enable idle high so the next read recaptures
        if (tmr_done) begin // see [RL10]
          tmr_start = 1'b1;
          if (s_ff.gap_next_read) begin
            nxt_s.state = dpsem_pkg::DPSEM_ST_READ;
            nxt_s.sel_n = 1'b0;
            nxt_s.oe_n  = 1'b0;
          end else if (s_ff.cmd == dpsem_pkg::DPSEM_CMD_INIT &&
                       s_ff.flag_index != 3'(`DPSEM_FLAG_COUNT - 1)) begin
            // Walk all eight flags writing one
            nxt_s.flag_index = s_ff.flag_index + 3'h1; // see [RL16]
            nxt_s.state      = dpsem_pkg::DPSEM_ST_WRITE;
            nxt_s.sel_n      = 1'b0;
            nxt_s.rw_n       = 1'b0;
            nxt_s.data_oe    = 1'b1;
          end else begin
            tmr_start   = 1'b0;
            nxt_s.state = dpsem_pkg::DPSEM_ST_DONE;
          end
        end
      end
      dpsem_pkg::DPSEM_ST_READ: begin
        if (tmr_done) begin
          nxt_s.sel_n = 1'b1;
          nxt_s.oe_n  = 1'b1;
          tmr_start   = 1'b1;
          tmr_len     = GAP_LEN;
          nxt_s.state = dpsem_pkg::DPSEM_ST_GAP;
          if (flag_low(data_i)) begin
            // Read-back zero means this port owns the token
            nxt_s.granted       = 1'b1; // see [RL6] [RL15]
            nxt_s.gap_next_read = 1'b0;
          end else if (s_ff.polls == poll_limit_i) begin
            // Give up: write one to withdraw the pending request
            nxt_s.cmd           = dpsem_pkg::DPSEM_CMD_RELEASE; // see [RL13]
            nxt_s.wbit          = 1'b1;
            nxt_s.gap_next_read = 1'b0;
            nxt_s.state         = dpsem_pkg::DPSEM_ST_WRITE;
            nxt_s.sel_n         = 1'b0;
            nxt_s.rw_n          = 1'b0;
            nxt_s.data_oe       = 1'b1;
            tmr_len             = PHASE_LEN;
          end else begin
            // Still owned elsewhere; poll again after a gap
            nxt_s.polls = s_ff.polls + 8'h01; // see [RL12] [RL14]
          end
        end
      end
      dpsem_pkg::DPSEM_ST_DONE: begin
        nxt_s.done  = 1'b1;
        nxt_s.ready = 1'b1;
        nxt_s.state = dpsem_pkg::DPSEM_ST_IDLE;
      end
      default: begin
        // Park the pins idle so an illegal state never strobes the device
        nxt_s       = '0;
        nxt_s.sel_n = 1'b1;
        nxt_s.oe_n  = 1'b1;
        nxt_s.rw_n  = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_ff       <= '0;
      s_ff.sel_n <= 1'b1;
      s_ff.oe_n  <= 1'b1;
      s_ff.rw_n  <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state flops; high address bits stay zero
  assign cmd_ready_o           = s_ff.ready;
  assign done_o                = s_ff.done;
  assign granted_o             = s_ff.granted;
  assign flag_space_select_n_o = s_ff.sel_n;
  assign oe_n_o                = s_ff.oe_n;
  assign rw_n_o                = s_ff.rw_n;
  assign addr_o                = {{(`DPSEM_ADDR_W-`DPSEM_INDEX_W){1'b0}}, s_ff.flag_index}; // see [RL4]
  assign data_o                = {{(`DPSEM_DATA_W-1){1'b0}}, s_ff.wbit}; // see [RL5]
  assign data_oe_o             = s_ff.data_oe;
endmodule
`default_nettype wire

// File: include/dpsem_defines.svh
// Timing counts and field positions for the semaphore port controller
`ifndef DPSEM_DEFINES_SVH
`define DPSEM_DEFINES_SVH

`define DPSEM_FLAG_COUNT    8
`define DPSEM_INDEX_W       3
`define DPSEM_ADDR_W        15
`define DPSEM_DATA_W        16
`define DPSEM_FLAG_BIT      0
// Access phase length in ns and derived cycles at 40 MHz (25 ns), rounded up
`define DPSEM_PHASE_NS      50
`define DPSEM_CLK_NS        25
`define DPSEM_PHASE_CYC     ((`DPSEM_PHASE_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
// Gap with select and output enable high between reads, in cycles
`define DPSEM_GAP_CYC       2

`endif

// File: include/dpsem_pkg.sv
// Types shared by the semaphore port controller
package dpsem_pkg;
  typedef enum logic [1:0] {
    DPSEM_CMD_NONE    = 2'b00,
    DPSEM_CMD_ACQUIRE = 2'b01,
    DPSEM_CMD_RELEASE = 2'b10,
    DPSEM_CMD_INIT    = 2'b11
  } dpsem_cmd_type;

  // Gray order along write, gap, read, done
  typedef enum logic [2:0] {
    DPSEM_ST_IDLE  = 3'b000,
    DPSEM_ST_WRITE = 3'b001,
    DPSEM_ST_GAP   = 3'b011,
    DPSEM_ST_READ  = 3'b010,
    DPSEM_ST_DONE  = 3'b110
  } dpsem_state_type;

  typedef struct packed {
    logic        busy;
    logic [3:0]  cnt;
  } dpsem_phase_type;
endpackage

// File: tb/dpsem_flag_dev.sv
// Behavioural two-port semaphore device, index 0 left, 1 right
`timescale 1ns/1ps
`default_nettype none
module dpsem_flag_dev (
  input  wire logic             mclk_i,
  input  wire logic [1:0]       sel_n,
  input  wire logic [1:0]       oe_n,
  input  wire logic [1:0]       rw_n,
  input  wire logic [1:0][14:0] addr,
  input  wire logic [1:0][15:0] din,
  output wire logic [1:0][15:0] dout
);
  logic [1:0] req [8]; // Low means request; apart from the array
  logic [1:0] own [8];
  // Power-up state is a held token, so software must free it
  initial for (int i = 0; i < 8; i++) begin
    req[i] = 2'b00;
    own[i] = 2'b01;
  end
  // Writes, release hand-over and arbitration; ties go left
  always @(posedge mclk_i) begin
    for (int s = 0; s < 2; s++)
      if (!sel_n[s] && !rw_n[s]) req[addr[s][2:0]][s] = din[s][0];
    for (int i = 0; i < 8; i++) begin
      for (int s = 0; s < 2; s++)
        if (own[i][s] && req[i][s]) own[i] = req[i][!s] ? 2'b00 : 2'b01 << !s;
      if (own[i] == 2'b00) own[i] = !req[i][0] ? 2'b01 : {!req[i][1], 1'b0};
    end
  end
  // Captured read per side; idle lines toggle so stale data never looks valid
  for (genvar s = 0; s < 2; s++) begin : g_side
    wire logic act = !sel_n[s] && !oe_n[s];
    logic cap = 1'b1;
    logic lv = 1'b0;
    always @(posedge act) cap = !own[addr[s][2:0]][s];
    always @(posedge mclk_i) lv <= dout[s][0];
    assign dout[s] = act ? {16{cap}} : {16{!lv}};
  end
endmodule
`default_nettype wire

// File: tb/dpsem_port_ctrl_assertions.sv
// Pin-level checker for the semaphore port controller
`timescale 1ns/1ps
`default_nettype none
module dpsem_chk (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        cmd_valid_i,
  input wire logic [1:0]  cmd_i,
  input wire logic [2:0]  cmd_index_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic        granted_o,
  input wire logic        flag_space_select_n_o,
  input wire logic        oe_n_o,
  input wire logic        rw_n_o,
  input wire logic [14:0] addr_o,
  input wire logic [15:0] data_o,
  input wire logic        data_oe_o,
  input wire logic [15:0] data_i
);
  // ----
  // Pin relations
  // ----
  logic take;
  assign take = cmd_valid_i && cmd_ready_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  addr_high_a: assert property (addr_o[14:3] == '0)
    else $error("high address bits driven");
  wr_data_a: assert property (data_oe_o |-> data_o[15:1] == '0)
    else $error("unused data bits driven");
  acq_write_a: assert property (take && cmd_i == 2'd1 |=> !flag_space_select_n_o
    && !rw_n_o && data_oe_o && !data_o[0] && addr_o[2:0] == $past(cmd_index_i))
    else $error("acquire did not start with a zero write");
  rel_write_a: assert property (take && cmd_i == 2'd2 |=> !flag_space_select_n_o
    && !rw_n_o && data_oe_o && data_o[0])
    else $error("release did not write a one");
  // A read phase holds both strobes for three sampled edges, never a fourth
  poll_gap_a: assert property ((!oe_n_o && !flag_space_select_n_o)[*3]
    |=> oe_n_o || flag_space_select_n_o)
    else $error("read not broken between polls");
  read_bus_a: assert property (!oe_n_o |-> rw_n_o && !data_oe_o)
    else $error("data driven during read");
  won_flag_a: assert property ($rose(oe_n_o) && !$past(data_i[0])
    |-> ##[0:6] done_o && granted_o)
    else $error("zero read back not reported as granted");
  reset_idle_a: assert property (disable iff (1'b0) !nrst_i
    |=> flag_space_select_n_o && oe_n_o && !data_oe_o && !cmd_ready_o)
    else $error("pins active in reset");
endmodule
`default_nettype wire

// File: tb/test_dual_port_semaphore_flags.sv
// Testbench: controller on the left port, bench as the right processor
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_semaphore_flags;
  logic mclk_i = 0, nrst_i = 0, cmd_valid_i = 0, rs = 1, ro = 1, rw = 1;
  logic [1:0] cmd_i = 0;
  logic [2:0] cmd_index_i = 0;
  logic [7:0] poll_limit_i = 0;
  logic cmd_ready_o, done_o, granted_o, flag_space_select_n_o, oe_n_o, rw_n_o, data_oe_o;
  logic [14:0] addr_o, ra = 0;
  logic [15:0] data_o, rd = 0;
  wire logic [15:0] data_i;
  wire logic [1:0][15:0] dv;
  int err_count = 0, total_checks = 0, cyc = 0, m_own[8], m_rq[8][2];
  always #12.5 mclk_i = !mclk_i;
  dpsem_port_ctrl dut_u (.mclk_i, .nrst_i, .cmd_valid_i, .cmd_i, .cmd_index_i, .poll_limit_i,
    .cmd_ready_o, .done_o, .granted_o, .flag_space_select_n_o, .oe_n_o, .rw_n_o, .addr_o,
    .data_o, .data_oe_o, .data_i);
  dpsem_flag_dev dev_u (.mclk_i, .sel_n({rs, flag_space_select_n_o}), .oe_n({ro, oe_n_o}),
    .rw_n({rw, rw_n_o}), .addr({ra, addr_o}), .din({rd, data_o}), .dout(dv));
  assign data_i = dv[0];
  // ----
  // Reference model: side 0 controller, 1 bench, owner -1 free
  // ----
  task automatic m_wr(int s, int i, int v);
    m_rq[i][s] = v;
    if (m_own[i] == s && v) m_own[i] = m_rq[i][1-s] ? -1 : 1 - s;
    if (m_own[i] < 0) m_own[i] = !m_rq[i][0] ? 0 : !m_rq[i][1] ? 1 : -1;
  endtask
  task automatic chk(logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic dut_cmd(logic [1:0] c, logic [2:0] i, logic [7:0] pl);
    int n = 0;
    while (cmd_ready_o !== 1'b1 && n < 99) begin @(posedge mclk_i); #2; n++; end
    {cmd_i, cmd_index_i, poll_limit_i, cmd_valid_i} = {c, i, pl, 1'b1};
    @(posedge mclk_i); #2;
    cmd_valid_i = 0;
    while (done_o !== 1'b1 && n < 3000) begin @(posedge mclk_i); #2; n++; end
    // Done pulse and ready come back together; a hung command fails here
    chk({14'b0, done_o, cmd_ready_o}, 16'h0003);
  endtask
  // Right port access, two cycles, random high address and data bits, then a gap
  task automatic rt(logic wr, logic [2:0] i, logic v, output logic [15:0] q);
    ra = {12'($urandom), i};
    rd = {15'($urandom), v};
    {rs, ro, rw} = {1'b0, wr, !wr};
    repeat (2) @(posedge mclk_i); #2;
    q = dv[1];
    {rs, ro, rw} = 3'b111;
    @(posedge mclk_i); #2;
  endtask
  task final_report;
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin err_count++; final_report; end
  end
  initial begin
    logic [15:0] q;
    int i;
    void'($urandom(32'hb73d));
    for (i = 0; i < 8; i++) begin m_own[i] = 0; m_rq[i] = '{0, 0}; end
    repeat (16) @(posedge mclk_i); #2;
    nrst_i = 1;
    rt(0, 3'd5, 0, q);
    chk(q, 16'hffff);
    dut_cmd(2'd3, 3'd0, 8'd0);
    // The power-up holder let go, so the right side now holds every flag
    for (i = 0; i < 8; i++) begin
      m_wr(0, i, 1);
      rt(0, 3'(i), 0, q);
      chk(q, m_own[i] == 1 ? 16'h0000 : 16'hffff);
      rt(1, 3'(i), 1, q);
      m_wr(1, i, 1);
    end
    for (i = 0; i < 8; i++) begin
      rt(0, 3'(i), 0, q);
      chk(q, 16'hffff);
    end
    // An empty command is swallowed without selecting the flag space or pulsing done
    {cmd_i, cmd_valid_i} = {2'd0, 1'b1};
    @(posedge mclk_i); #2;
    cmd_valid_i = 0;
    repeat (2) @(posedge mclk_i); #2;
    chk({14'b0, flag_space_select_n_o, done_o}, 16'h0002);
    // Same-edge requests from both sides: exactly one may win
    fork
      dut_cmd(2'd1, 3'd6, 8'd0);
      begin @(posedge mclk_i); #2; rt(1, 3'd6, 0, q); end
    join
    rt(0, 3'd6, 0, q);
    chk({15'b0, granted_o}, {15'b0, q[0]});
    if (granted_o) begin m_wr(0, 6, 0); m_wr(1, 6, 0); end
    else begin m_wr(1, 6, 0); m_wr(0, 6, 0); m_wr(0, 6, 1); end
    // Random traffic on two flags keeps hitting pending and hand-over cases
    repeat (40) begin
      i = 6 + $urandom % 2;
      case ($urandom % 4)
        0: begin rt(1, 3'(i), 0, q); m_wr(1, i, 0); end
        1: begin rt(1, 3'(i), 1, q); m_wr(1, i, 1); end
        2: begin
          dut_cmd(2'd1, 3'(i), 8'($urandom % 3));
          m_wr(0, i, 0);
          chk({15'b0, granted_o}, {15'b0, m_own[i] == 0});
          if (m_own[i] != 0) m_wr(0, i, 1);
        end
        default: begin dut_cmd(2'd2, 3'(i), 8'd0); m_wr(0, i, 1); end
      endcase
      rt(0, 3'(i), 0, q);
      chk(q, m_own[i] == 1 ? 16'h0000 : 16'hffff);
    end
    final_report;
  end
endmodule
bind dpsem_port_ctrl dpsem_chk chk_u (.mclk_i, .nrst_i, .cmd_valid_i, .cmd_i, .cmd_index_i,
  .cmd_ready_o, .done_o, .granted_o, .flag_space_select_n_o, .oe_n_o, .rw_n_o, .addr_o,
  .data_o, .data_oe_o, .data_i);
`default_nettype wire
